// ### logic/had_pkg.sv
// constants, register map and types of the hdmi audio dma
package had_pkg;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 256;
  localparam int LVL_W = 9;
  localparam int PTR_W = 8;
  localparam logic [LVL_W-1:0] FIFO_DEPTH_LVL = 9'h100;
  // register indices; byte address is four times the index
  localparam logic [29:0] IDX_CONFIG = 30'h00123600;
  localparam logic [29:0] IDX_THRESH = 30'h00123603;
  localparam logic [29:0] IDX_START_ADDR0 = 30'h00123604;
  localparam logic [29:0] IDX_STOP_ADDR0 = 30'h00123608;
  localparam logic [29:0] IDX_START = 30'h0012360c;
  localparam logic [29:0] IDX_STOP = 30'h0012360d;
  localparam logic [29:0] IDX_CHAN = 30'h0012360e;
  localparam logic [29:0] IDX_IRQ_STAT = 30'h0012360f;
  localparam logic [29:0] IDX_LEVEL = 30'h00123610;
  localparam int START_BIT = 0;
  localparam int STOP_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int DONE_BIT = 2;
  localparam int ERR_BIT = 3;
  localparam int CFG_TYPE_LSB = 1;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] THRESH_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [7:0] CHAN_ALL = 8'hff;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [2:0] HBURST_INCR = 3'h1;
  localparam logic [2:0] HBURST_INCR4 = 3'h3;
  localparam logic [2:0] HBURST_INCR8 = 3'h5;
  localparam logic [2:0] HBURST_INCR16 = 3'h7;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [31:0] WORD_BYTES = 32'h4;
  localparam logic [4:0] INCR_BEATS = 5'h04;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BURST} had_state_type;
endpackage : had_pkg

// ### logic/had_fifo.sv
// sample fifo between bus fetches and the link
`timescale 1ns/1ps
module had_fifo (
  input wire logic clock,
  input wire logic rst,
  input wire logic push,
  input wire logic [had_pkg::DATA_W-1:0] push_data,
  input wire logic pop,
  output logic [had_pkg::DATA_W-1:0] pop_data_r,
  output logic pop_valid_r,
  output logic [had_pkg::LVL_W-1:0] level_r,
  output logic full
);
  logic [had_pkg::DATA_W-1:0] mem [had_pkg::FIFO_DEPTH];
  logic [had_pkg::PTR_W-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [had_pkg::LVL_W-1:0] level_nxt;
  logic do_push, do_pop;

  assign full = (level_r == had_pkg::FIFO_DEPTH_LVL);

  always_comb begin
    do_push = push && !full;
    do_pop = pop && (level_r != '0);
    wr_nxt = do_push ? wr_r + 8'h01 : wr_r;
    rd_nxt = do_pop ? rd_r + 8'h01 : rd_r;
    level_nxt = level_r + {8'h00, do_push} - {8'h00, do_pop};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      level_r <= '0;
      pop_valid_r <= 1'b0;
      pop_data_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      level_r <= level_nxt;
      // valid low on a pop from empty shows underflow to the link
      pop_valid_r <= do_pop;
      if (do_pop) begin
        pop_data_r <= mem[rd_r];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_r] <= push_data;
    end
  end
endmodule : had_fifo

// ### logic/had_burst_sel.sv
// burst length and type for the next fetch
`timescale 1ns/1ps
module had_burst_sel (
  input wire logic [1:0] burst_type,
  input wire logic [31:0] rem_words,
  output logic [4:0] beats,
  output logic [2:0] hburst
);
  logic [4:0] len;
  logic [2:0] code;

  always_comb begin
    case (burst_type)
      2'h0: begin
        len = had_pkg::INCR_BEATS;
        code = had_pkg::HBURST_INCR;
      end
      2'h1: begin
        len = 5'h04;
        code = had_pkg::HBURST_INCR4;
      end
      2'h2: begin
        len = 5'h08;
        code = had_pkg::HBURST_INCR8;
      end
      default: begin
        len = 5'h10;
        code = had_pkg::HBURST_INCR16;
      end
    endcase
    // a short tail never runs past the stop address
    if (rem_words < {27'h0, len}) begin
      beats = rem_words[4:0];
      hburst = had_pkg::HBURST_INCR;
    end else begin
      beats = len;
      hburst = code;
    end
  end
endmodule : had_burst_sel

// ### logic/had_dma_top.sv
// audio dma: apb registers, ahb read master and sample fifo
`timescale 1ns/1ps
module had_dma_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic [2:0] hburst,
  output logic [2:0] hsize,
  output logic hwrite,
  input wire logic hready,
  input wire logic [1:0] hresp,
  input wire logic [31:0] hrdata,
  input wire logic link_rd,
  output logic [31:0] link_data,
  output logic link_valid,
  output logic [7:0] chan_enable,
  output logic dma_done
);
  // register file
  logic [7:0] cfg_r, cfg_nxt, thr_r, thr_nxt, chan_r, chan_nxt;
  logic [7:0] start_b_r [4];
  logic [7:0] start_b_nxt [4];
  logic [7:0] stop_b_r [4];
  logic [7:0] stop_b_nxt [4];
  logic done_st_r, done_st_nxt, err_st_r, err_st_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  // dma engine
  had_pkg::had_state_type st_r, st_nxt;
  logic [31:0] addr_r, addr_nxt, haddr_r, haddr_nxt;
  logic [1:0] htrans_r, htrans_nxt;
  logic [2:0] hburst_r, hburst_nxt, hsize_r;
  logic hwrite_r;
  logic [4:0] beats_r, beats_nxt;
  logic dph_r, dph_nxt, last_r, last_nxt;
  logic stop_r, stop_nxt, lock_r, lock_nxt, err_r, err_nxt;
  logic [7:0] chan_en_r;
  // shared terms
  logic [29:0] idx;
  logic setup, wr_acc, hit;
  logic start_wr, stop_wr, done_ev, err_ev;
  logic [31:0] start_addr, stop_addr, rem_words;
  logic [4:0] sel_beats;
  logic [2:0] sel_hburst;
  logic push, fifo_full;
  logic [had_pkg::LVL_W-1:0] level;
  logic [had_pkg::LVL_W-1:0] free_words;

  assign idx = paddr[31:2];
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready_r && pwrite;
  assign start_addr = {start_b_r[3], start_b_r[2], start_b_r[1], start_b_r[0]};
  assign stop_addr = {stop_b_r[3], stop_b_r[2], stop_b_r[1], stop_b_r[0]};
  assign rem_words = ((stop_addr - addr_r) >> 2) + 32'h1;
  assign free_words = had_pkg::FIFO_DEPTH_LVL - level;
  assign start_wr = wr_acc && (idx == had_pkg::IDX_START)
    && pwdata[had_pkg::START_BIT];
  assign stop_wr = wr_acc && (idx == had_pkg::IDX_STOP)
    && pwdata[had_pkg::STOP_BIT];

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign haddr = haddr_r;
  assign htrans = htrans_r;
  assign hburst = hburst_r;
  assign hsize = hsize_r;
  assign hwrite = hwrite_r;
  assign chan_enable = chan_en_r;
  assign dma_done = done_st_r;

  had_burst_sel u_sel (
    .burst_type(cfg_r[had_pkg::CFG_TYPE_LSB +: 2]),
    .rem_words(rem_words),
    .beats(sel_beats),
    .hburst(sel_hburst)
  );

  had_fifo u_fifo (
    .clock(clock),
    .rst(rst),
    .push(push),
    .push_data(hrdata),
    .pop(link_rd),
    .pop_data_r(link_data),
    .pop_valid_r(link_valid),
    .level_r(level),
    .full(fifo_full)
  );

  // apb slave: answers in the first access cycle
  always_comb begin
    cfg_nxt = cfg_r;
    thr_nxt = thr_r;
    chan_nxt = chan_r;
    start_b_nxt = start_b_r;
    stop_b_nxt = stop_b_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt = setup;
    hit = 1'b1;
    case (idx)
      had_pkg::IDX_CONFIG: prdata_nxt = {24'h0, cfg_r};
      had_pkg::IDX_THRESH: prdata_nxt = {24'h0, thr_r};
      had_pkg::IDX_START: prdata_nxt = {30'h0, st_r != had_pkg::ST_IDLE, 1'b0};
      had_pkg::IDX_STOP: prdata_nxt = {31'h0, stop_r};
      had_pkg::IDX_CHAN: prdata_nxt = {24'h0, chan_r};
      had_pkg::IDX_IRQ_STAT: prdata_nxt = {28'h0, err_st_r, done_st_r, 2'h0};
      had_pkg::IDX_LEVEL: prdata_nxt = {23'h0, level};
      default: begin
        prdata_nxt = 32'h0;
        hit = 1'b0;
      end
    endcase
    for (int i = 0; i < 4; i++) begin
      if (idx == had_pkg::IDX_START_ADDR0 + 30'(i)) begin
        prdata_nxt = {24'h0, start_b_r[i]};
        hit = 1'b1;
      end
      if (idx == had_pkg::IDX_STOP_ADDR0 + 30'(i)) begin
        prdata_nxt = {24'h0, stop_b_r[i]};
        hit = 1'b1;
      end
      if (wr_acc && idx == had_pkg::IDX_START_ADDR0 + 30'(i)) begin
        start_b_nxt[i] = pwdata[7:0];
      end
      if (wr_acc && idx == had_pkg::IDX_STOP_ADDR0 + 30'(i)) begin
        stop_b_nxt[i] = pwdata[7:0];
      end
    end
    if (!setup) begin
      // error flag stands only in the access cycle, like pready
      prdata_nxt = 32'h0;
      pslverr_nxt = 1'b0;
    end else begin
      pslverr_nxt = !hit;
    end
    if (wr_acc) begin
      case (idx)
        had_pkg::IDX_CONFIG: cfg_nxt = {pwdata[7:1], 1'b0};
        had_pkg::IDX_THRESH: thr_nxt = pwdata[7:0];
        had_pkg::IDX_CHAN: chan_nxt = pwdata[7:0];
        default: cfg_nxt = cfg_r;
      endcase
    end
    // write one to clear; a same-cycle event wins
    done_st_nxt = done_st_r;
    err_st_nxt = err_st_r;
    if (wr_acc && idx == had_pkg::IDX_IRQ_STAT) begin
      done_st_nxt = done_st_r && !pwdata[had_pkg::DONE_BIT];
      err_st_nxt = err_st_r && !pwdata[had_pkg::ERR_BIT];
    end
    if (done_ev) begin
      done_st_nxt = 1'b1;
    end
    if (err_ev) begin
      err_st_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_r <= had_pkg::CONFIG_RST;
      thr_r <= had_pkg::THRESH_RST;
      chan_r <= had_pkg::CHAN_RST;
      start_b_r <= '{default: 8'h00};
      stop_b_r <= '{default: 8'h00};
      done_st_r <= 1'b0;
      err_st_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      thr_r <= thr_nxt;
      chan_r <= chan_nxt;
      start_b_r <= start_b_nxt;
      stop_b_r <= stop_b_nxt;
      done_st_r <= done_st_nxt;
      err_st_r <= err_st_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ahb read engine
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    haddr_nxt = haddr_r;
    htrans_nxt = htrans_r;
    hburst_nxt = hburst_r;
    beats_nxt = beats_r;
    dph_nxt = dph_r;
    last_nxt = last_r;
    err_nxt = err_r;
    done_ev = 1'b0;
    err_ev = 1'b0;
    push = 1'b0;
    // set on full wins over release at threshold
    lock_nxt = lock_r;
    if (level <= {1'b0, thr_r}) begin
      lock_nxt = 1'b0;
    end
    if (fifo_full) begin
      lock_nxt = 1'b1;
    end
    stop_nxt = stop_r || (stop_wr && st_r != had_pkg::ST_IDLE);
    case (st_r)
      had_pkg::ST_IDLE: begin
        if (start_wr) begin
          st_nxt = had_pkg::ST_WAIT;
          addr_nxt = {start_addr[31:2], 2'h0};
          err_nxt = 1'b0;
          lock_nxt = 1'b0;
        end
      end
      had_pkg::ST_WAIT: begin
        if (stop_r || stop_wr) begin
          // no bus cycle is open here, so stop ends at once
          st_nxt = had_pkg::ST_IDLE;
          done_ev = 1'b1;
        end else if (addr_r > stop_addr) begin
          st_nxt = had_pkg::ST_IDLE;
          done_ev = 1'b1;
        end else if (!lock_r && hready
                     && free_words >= {4'h0, sel_beats}) begin
          st_nxt = had_pkg::ST_BURST;
          haddr_nxt = addr_r;
          htrans_nxt = had_pkg::HTRANS_NONSEQ;
          hburst_nxt = sel_hburst;
          beats_nxt = sel_beats - 5'h01;
          addr_nxt = addr_r + had_pkg::WORD_BYTES;
        end
      end
      had_pkg::ST_BURST: begin
        if (hresp != had_pkg::HRESP_OKAY) begin
          err_nxt = 1'b1;
          err_ev = !err_r;
        end
        if (hready) begin
          if (dph_r && hresp == had_pkg::HRESP_OKAY && !err_r) begin
            push = 1'b1;
          end
          dph_nxt = (htrans_r != had_pkg::HTRANS_IDLE);
          last_nxt = (haddr_r == {stop_addr[31:2], 2'h0});
          if (beats_r != 5'h00 && !stop_r && !stop_wr) begin
            haddr_nxt = addr_r;
            htrans_nxt = had_pkg::HTRANS_SEQ;
            beats_nxt = beats_r - 5'h01;
            addr_nxt = addr_r + had_pkg::WORD_BYTES;
          end else begin
            // stop cuts the burst short at the next beat
            htrans_nxt = had_pkg::HTRANS_IDLE;
            beats_nxt = 5'h00;
          end
          if (htrans_r == had_pkg::HTRANS_IDLE) begin
            dph_nxt = 1'b0;
            if (stop_r || stop_wr || last_r) begin
              st_nxt = had_pkg::ST_IDLE;
              done_ev = 1'b1;
            end else begin
              st_nxt = had_pkg::ST_WAIT;
            end
          end
        end
      end
      default: st_nxt = had_pkg::ST_IDLE;
    endcase
    if (st_nxt == had_pkg::ST_IDLE) begin
      stop_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= had_pkg::ST_IDLE;
      addr_r <= 32'h0;
      haddr_r <= 32'h0;
      htrans_r <= had_pkg::HTRANS_IDLE;
      hburst_r <= had_pkg::HBURST_INCR;
      hsize_r <= had_pkg::HSIZE_WORD;
      hwrite_r <= 1'b0;
      beats_r <= 5'h00;
      dph_r <= 1'b0;
      last_r <= 1'b0;
      stop_r <= 1'b0;
      lock_r <= 1'b0;
      err_r <= 1'b0;
      chan_en_r <= had_pkg::CHAN_RST;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      haddr_r <= haddr_nxt;
      htrans_r <= htrans_nxt;
      hburst_r <= hburst_nxt;
      hsize_r <= had_pkg::HSIZE_WORD;
      hwrite_r <= 1'b0;
      beats_r <= beats_nxt;
      dph_r <= dph_nxt;
      last_r <= last_nxt;
      stop_r <= stop_nxt;
      lock_r <= lock_nxt;
      err_r <= err_nxt;
      // all ones opens every channel of the link
      chan_en_r <= (chan_r == had_pkg::CHAN_ALL) ? had_pkg::CHAN_ALL : chan_r;
    end
  end
endmodule : had_dma_top

// ### verification/had_dma_top_chk.sv
// port assertions for the audio dma top
`timescale 1ns/1ps
module had_dma_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hburst,
  input wire logic hready,
  input wire logic [7:0] chan_enable,
  input wire logic dma_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_zero_wait: assert property (psel && !penable |=> pready)
    else $error("apb access not answered at once");
  chk_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("slave error outside an access");
  // level is wider than a byte, so it is left out
  chk_byte_read: assert property (pready && !pwrite && paddr[31:2] != had_pkg::IDX_LEVEL
    |-> prdata[31:8] == 24'h0) else $error("byte register read with upper bits set");
  chk_addr_hold: assert property (htrans != 2'h0 && !hready |=> $stable(haddr) && $stable(htrans))
    else $error("ahb address changed while stalled");
  chk_seq_step: assert property ((hready && htrans != 2'h0) ##1 htrans == 2'h3
    |-> haddr == $past(haddr) + 32'h4) else $error("burst address step is not one word");
  chk_burst_open: assert property (htrans != 2'h0 && $past(htrans) == 2'h0 |-> htrans == 2'h2)
    else $error("burst opened without nonseq");
  chk_burst_kind: assert property (htrans == 2'h2 |-> hburst inside {3'h1, 3'h3, 3'h5, 3'h7})
    else $error("burst kind is not incrementing");
  chk_done_idle: assert property ($rose(dma_done) |-> (htrans == 2'h0)[*3])
    else $error("bus active after done");
  chk_chan_copy: assert property (psel && penable && pready && pwrite
    && paddr[31:2] == had_pkg::IDX_CHAN |=> ##1 chan_enable == $past(pwdata[7:0], 2))
    else $error("channel enables differ from register");
  cover property ($rose(dma_done));
  cover property (pslverr);
  cover property (htrans == 2'h2 && hburst == 3'h7);
endmodule : had_dma_chk

// ### verification/had_ahb_mem.sv
// ahb memory slave answering the dma reads
`timescale 1ns/1ps
module had_ahb_mem (
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic slow,
  input wire logic err_en,
  input wire logic [31:0] err_addr,
  output logic hready,
  output logic [1:0] hresp,
  output logic [31:0] hrdata
);
  logic [31:0] da_r;
  // word at a reads as ~a; an idle bus shows a pattern that flips every cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      hready <= 1'h1;
      hresp <= 2'h0;
      hrdata <= 32'h0;
      da_r <= 32'h0;
    end else if (hready && htrans[1]) begin
      da_r <= haddr;
      hready <= !slow;
      hrdata <= slow ? ~hrdata : ~haddr;
      hresp <= {1'h0, err_en && !slow && haddr == err_addr};
    end else if (!hready) begin
      hready <= 1'h1;
      hrdata <= ~da_r;
      hresp <= {1'h0, err_en && da_r == err_addr};
    end else begin
      hrdata <= ~hrdata;
      hresp <= 2'h0;
    end
  end
endmodule : had_ahb_mem

// ### verification/test_hdmi_audio_ahb_dma.sv
// self-checking bench for the audio dma
`timescale 1ns/1ps
module test_hdmi_audio_ahb_dma;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, hwrite, hready, er;
  logic link_rd, link_valid, dma_done, slow, err_en, drain;
  logic [31:0] paddr, pwdata, prdata, haddr, hrdata, link_data, rd, exp_a, err_addr;
  logic [1:0] htrans, hresp;
  logic [2:0] hburst, hsize, exp_hb;
  logic [7:0] chan_enable;
  int n_errors, comparisons, rx, nreq;

  had_dma_top i_had_dma_top (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .haddr, .htrans, .hburst, .hsize, .hwrite, .hready,
    .hresp, .hrdata, .link_rd, .link_data, .link_valid, .chan_enable, .dma_done);
  had_ahb_mem i_had_ahb_mem (.clock, .rst, .haddr, .htrans, .slow, .err_en, .err_addr,
    .hready, .hresp, .hrdata);

  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [29:0] i, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    // no bound here: a slave that never answers is caught by the watchdog
    do @(posedge clock); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [29:0] i, input logic [31:0] d);
    apb(1'h1, i, d);
  endtask : wr

  task automatic rchk(input string s, input logic [29:0] i, input logic [31:0] e);
    apb(1'h0, i, 32'h0);
    chk(s, e, rd);
  endtask : rchk

  // one cycle, counting new bursts that the slave accepts
  task automatic step();
    @(posedge clock);
    if (htrans === 2'h2 && hready === 1'h1) begin
      nreq++;
      chk("burst attrs", {25'h0, exp_hb, 4'h4}, {25'h0, hburst, hsize, hwrite});
    end
  endtask : step

  task automatic wait_rx(input int w);
    for (int n = 0; n < 2000 && rx < w; n++) step();
  endtask : wait_rx

  task automatic wait_done();
    for (int n = 0; n < 3000 && dma_done !== 1'h1; n++) step();
    chk("dma_done", 32'h1, {31'h0, dma_done});
  endtask : wait_done

  task automatic run(input logic [31:0] s, input logic [31:0] e, input logic [7:0] cfg);
    for (int k = 0; k < 4; k++) begin
      wr(had_pkg::IDX_START_ADDR0 + 30'(k), {24'h0, s[8*k +: 8]});
      wr(had_pkg::IDX_STOP_ADDR0 + 30'(k), {24'h0, e[8*k +: 8]});
    end
    wr(had_pkg::IDX_CONFIG, {24'h0, cfg});
    wr(had_pkg::IDX_THRESH, 32'h7e);
    wr(had_pkg::IDX_IRQ_STAT, 32'hc);
    exp_a = s;
    // ahb codes: incr 1, incr4 3, incr8 5, incr16 7; no scenario has a short tail
    exp_hb = {cfg[2:1], 1'h1};
    rx = 0;
    wr(had_pkg::IDX_START, 32'h1);
  endtask : run

  task automatic t_regs();
    rchk("config reset", had_pkg::IDX_CONFIG, 32'h0);
    rchk("threshold reset", had_pkg::IDX_THRESH, 32'h0);
    wr(had_pkg::IDX_CONFIG, 32'h7);
    rchk("config", had_pkg::IDX_CONFIG, 32'h6);
    wr(had_pkg::IDX_THRESH, 32'h1ab);
    rchk("threshold", had_pkg::IDX_THRESH, 32'hab);
    apb(1'h0, 30'h3ff0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    wr(had_pkg::IDX_CHAN, 32'hff);
    repeat (2) @(posedge clock);
    chk("chan_enable", 32'hff, {24'h0, chan_enable});
  endtask : t_regs

  task automatic t_normal(input logic [7:0] cfg);
    drain <= 1'h1;
    run(32'h1000, 32'h10fc, cfg);
    wait_done();
    wait_rx(64);
    chk("words", 32'h40, 32'(rx));
    apb(1'h0, had_pkg::IDX_IRQ_STAT, 32'h0);
    chk("status done", 32'h4, rd & 32'h4);
    nreq = 0;
    wait_rx(65);
    chk("requests when idle", 32'h0, 32'(nreq));
  endtask : t_normal

  task automatic t_error();
    drain <= 1'h1;
    err_addr <= 32'h2008;
    err_en <= 1'h1;
    // region long enough that the stop lands while fetching goes on
    run(32'h2000, 32'h3ffc, 8'h0);
    wait_rx(3);
    chk("words before error", 32'h2, 32'(rx));
    rchk("busy before stop", had_pkg::IDX_START, 32'h2);
    wr(had_pkg::IDX_STOP, 32'h1);
    wait_done();
    nreq = 0;
    repeat (50) step();
    chk("requests after stop", 32'h0, 32'(nreq));
    apb(1'h0, had_pkg::IDX_IRQ_STAT, 32'h0);
    chk("status done error", 32'hc, rd & 32'hc);
    err_en <= 1'h0;
  endtask : t_error

  // fill to full with a stalling slave, then drain above the threshold
  task automatic t_full();
    drain <= 1'h0;
    slow <= 1'h1;
    run(32'h4000, 32'h47fc, 8'h6);
    for (int k = 0; k < 30; k++) begin
      nreq = 0;
      repeat (100) step();
      if (nreq == 0) break;
    end
    drain <= 1'h1;
    wait_rx(100);
    drain <= 1'h0;
    chk("requests while locked", 32'h0, 32'(nreq));
    wr(had_pkg::IDX_STOP, 32'h1);
    wait_done();
    nreq = 0;
    drain <= 1'h1;
    wait_rx(257);
    chk("fifo depth", 32'h100, 32'(rx));
    chk("requests after stop", 32'h0, 32'(nreq));
    rchk("level empty", had_pkg::IDX_LEVEL, 32'h0);
  endtask : t_full

  always @(posedge clock) begin
    link_rd <= drain && !link_rd;
    if (link_valid === 1'h1) begin
      chk("link_data", ~exp_a, link_data);
      exp_a = exp_a + 32'h4;
      rx++;
    end
  end

  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    {psel, penable, pwrite, link_rd, slow, err_en, drain} = 7'h0;
    {paddr, pwdata, err_addr, exp_a} = 128'h0;
    rst = 1'h1;
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    t_regs();
    t_normal(8'h2);
    t_normal(8'h4);
    t_error();
    t_full();
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    end_sim();
  end
endmodule : test_hdmi_audio_ahb_dma

bind had_dma_top had_dma_chk i_had_dma_chk (.clock, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .haddr, .htrans, .hburst, .hready, .chan_enable,
  .dma_done);
